// *** clsa_alu.sv ***
// Sequenced datapath: takes a request, holds it for its clock count, answers
`include "clsa_defs.svh"
module clsa_alu (
  input wire logic clk_i, // CPU clock
  input wire logic rst_i, // Synchronous reset, active high
  input wire logic cpu_en_i, // One pulse per selected CPU clock cycle
  input wire logic start_i, // Request valid
  input wire clsa_pkg::clsa_req_t req_i, // Request
  input wire clsa_pkg::clsa_flags_t flags_i, // Flags in
  output logic busy_o, // Operation in progress
  output logic done_o, // Result valid, one cycle
  output clsa_pkg::clsa_res_t res_o // Result, flags, address
);
  typedef enum logic [0:0] {
    CLSA_IDLE = 1'b0,
    CLSA_RUN = 1'b1
  } clsa_state_t;
  clsa_state_t state_reg;
  clsa_state_t state_next;
  clsa_pkg::clsa_req_t req_reg;
  logic [2:0] cnt_reg;
  logic [2:0] need;
  logic [2:0] need_reg;
  logic [2:0] cnt_next;
  logic busy_reg;
  logic done_reg;
  clsa_pkg::clsa_res_t res_reg;
  clsa_pkg::clsa_res_t core_res;
  logic finish;
  // Instruction clock count from operation and operand area
  function automatic logic [2:0] clocks(input clsa_pkg::clsa_req_t r);
    logic rmw;
    rmw = (r.op == clsa_pkg::CLSA_INC) || (r.op == clsa_pkg::CLSA_BDEC) ||
          (r.op == clsa_pkg::CLSA_WINC) || (r.op == clsa_pkg::CLSA_WDEC);
    if (r.area == clsa_pkg::CLSA_AREA_PROG && !rmw)
      clocks = r.seg ? `CLSA_CLK_PROG_EXT : `CLSA_CLK_PROG;
    else if (rmw && r.mem)
      clocks = r.seg ? `CLSA_CLK_EXT_RMW : `CLSA_CLK_RMW;
    else if (((r.op == clsa_pkg::CLSA_OR) || (r.op == clsa_pkg::CLSA_XOR)) && r.mem_imm)
      clocks = `CLSA_CLK_RMW;
    else if (r.seg)
      clocks = `CLSA_CLK_RMW;
    else
      clocks = `CLSA_CLK_SHORT;
  endfunction
  assign need = clocks(req_i);
  assign finish = (state_reg == CLSA_RUN) && cpu_en_i && (cnt_reg == need_reg);
  assign cnt_next = cpu_en_i ? cnt_reg + 3'h1 : cnt_reg;
  clsa_core u_core (
    .req_i(req_reg),
    .flags_i(flags_i),
    .res_o(core_res)
  );
  // Next state
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      CLSA_IDLE: if (start_i) state_next = CLSA_RUN;
      CLSA_RUN: if (finish) state_next = CLSA_IDLE;
    endcase
  end
  // Request capture and clock counting
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= CLSA_IDLE;
      req_reg <= '0;
      need_reg <= `CLSA_CLK_SHORT;
      cnt_reg <= 3'h0;
    end else begin
      state_reg <= state_next;
      if (state_reg == CLSA_IDLE && start_i) begin
        req_reg <= req_i;
        need_reg <= need;
        cnt_reg <= 3'h1;
      end else if (state_reg == CLSA_RUN) begin
        cnt_reg <= cnt_next;
      end
    end
  end
  // Registered outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      res_reg <= '0;
    end else begin
      busy_reg <= (state_next == CLSA_RUN);
      done_reg <= finish;
      if (finish) res_reg <= core_res;
    end
  end
  assign busy_o = busy_reg;
  assign done_o = done_reg;
  assign res_o = res_reg;
endmodule

// *** clsa_alu_asserts.sv ***
// Assertions on the ports of the sequenced datapath
module clsa_alu_asserts (
  input wire logic clk_i, // CPU clock
  input wire logic rst_i, // Reset
  input wire logic cpu_en_i, // Instruction clock enable
  input wire logic start_i, // Request valid
  input wire clsa_pkg::clsa_req_t req_i, // Request
  input wire clsa_pkg::clsa_flags_t flags_i, // Flags in
  input wire logic busy_o, // Busy
  input wire logic done_o, // Result valid
  input wire clsa_pkg::clsa_res_t res_o // Result
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  clsa_pkg::clsa_req_t q_reg;
  wire take = start_i && !busy_o;
  wire [4:0] op = q_reg.op;
  wire [7:0] a = q_reg.dst[7:0];
  // Keep the request that is being answered
  always_ff @(posedge clk_i) begin
    if (take) begin
      q_reg <= req_i;
    end
  end
  chk_done_single: assert property (done_o |=> !done_o)
    else $error("done held too long");
  chk_take_busy: assert property (take |=> busy_o && !done_o)
    else $error("request not taken");
  chk_answer_bound: assert property (take |-> ##[2:96] done_o)
    else $error("no answer in time");
  chk_logic_keep: assert property (done_o && op inside {5'h00, 5'h01} |->
    res_o.flags[1:0] == flags_i[1:0] && res_o.flags[2] == (res_o.value == 16'h0000))
    else $error("logic flags wrong");
  chk_cmp_nowrite: assert property (done_o && op inside {5'h02, 5'h03, 5'h04, 5'h07}
    |-> !res_o.write_back)
    else $error("compare wrote back");
  chk_mul_product: assert property (done_o && op == 5'h08 |->
    res_o.value == a * q_reg.src[7:0] && res_o.flags == flags_i)
    else $error("product wrong");
  chk_word_step: assert property (done_o && op inside {5'h0b, 5'h0c} |->
    res_o.flags == flags_i)
    else $error("word step touched flags");
  chk_lsr_fill: assert property (done_o && op == 5'h0d |->
    res_o.value == {8'h00, a >> q_reg.cnt} && res_o.flags[2:1] == flags_i[2:1])
    else $error("logic shift wrong");
  chk_arith_sign: assert property (done_o && op == 5'h11 |->
    res_o.value == {8'h00, 8'($signed(a) >>> q_reg.cnt)})
    else $error("arith shift wrong");
  chk_ext_addr: assert property (done_o && q_reg.seg |->
    res_o.ext_addr == {q_reg.bank, q_reg.addr})
    else $error("extended address wrong");
  cover property (done_o && q_reg.seg);
  cover property (take && req_i.area == clsa_pkg::CLSA_AREA_PROG);
  cover property (take && !cpu_en_i);
endmodule
bind clsa_alu clsa_alu_asserts u_chk (.clk_i(clk_i), .rst_i(rst_i), .cpu_en_i(cpu_en_i),
  .start_i(start_i), .req_i(req_i), .flags_i(flags_i), .busy_o(busy_o), .done_o(done_o),
  .res_o(res_o));

// *** clsa_clk_sel_model.sv ***
// Model of the clock selection that paces instruction clocks
module clsa_clk_sel_model (
  input wire logic clk_i, // CPU clock
  input wire logic rst_i, // Reset
  input wire logic [1:0] div_i, // Idle cycles between pulses
  output logic cpu_en_o // One pulse per instruction clock
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] cnt_reg;
  // Count down between enable pulses
  always_ff @(posedge clk_i) begin
    if (rst_i || cnt_reg == 2'h0) begin
      cnt_reg <= div_i;
    end else begin
      cnt_reg <= cnt_reg - 2'h1;
    end
  end
  assign cpu_en_o = (cnt_reg == 2'h0);
endmodule

// *** clsa_core.sv ***
// Combinational arithmetic, logic and shift unit
`include "clsa_defs.svh"
module clsa_core (
  input wire clsa_pkg::clsa_req_t req_i, // Operation and operands
  input wire clsa_pkg::clsa_flags_t flags_i, // Flags before the operation
  output clsa_pkg::clsa_res_t res_o // Result and flags after
);
  // Subtract with half-borrow and borrow for bytes
  function automatic logic [9:0] sub8(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] d;
    logic [4:0] h;
    d = {1'b0, a} - {1'b0, b};
    h = {1'b0, a[3:0]} - {1'b0, b[3:0]};
    sub8 = {d[8], h[4], d[7:0]};
  endfunction
  // Add or subtract on words, carry from bit 15, half from bit 3
  function automatic logic [17:0] arith16(input logic [15:0] a, input logic [15:0] b,
                                          input logic sub);
    logic [16:0] r;
    logic [4:0] h;
    r = sub ? ({1'b0, a} - {1'b0, b}) : ({1'b0, a} + {1'b0, b});
    h = sub ? ({1'b0, a[3:0]} - {1'b0, b[3:0]}) : ({1'b0, a[3:0]} + {1'b0, b[3:0]});
    arith16 = {r[16], h[4], r[15:0]};
  endfunction
  logic [7:0] a8;
  logic [7:0] b8;
  logic [3:0] n;
  logic [9:0] s8;
  logic [17:0] w16;
  logic [15:0] lsr_w;
  logic [15:0] lsl_w;
  logic [15:0] asr_w;
  logic [7:0] asr_b;
  logic [7:0] sh_b;
  logic lsr_c;
  logic lsl_c;
  logic lslb_c;
  logic asr_c;
  logic wlsr_c;
  logic wasr_c;
  logic cnt_nz;
  assign a8 = req_i.dst[7:0];
  assign b8 = req_i.src[7:0];
  assign n = req_i.cnt;
  assign cnt_nz = (n != 4'h0);
  assign s8 = sub8(a8, b8);
  assign w16 = arith16(req_i.dst, req_i.src, req_i.op != clsa_pkg::CLSA_WADD);
  // Shift results; carry is the last bit shifted out
  assign sh_b = a8 >> n;
  assign lsr_c = cnt_nz && (n <= 4'h8) && a8[3'(n - 4'h1)];
  assign lsl_w = req_i.dst << n;
  assign lsl_c = cnt_nz && req_i.dst[4'(5'h10 - {1'b0, n})];
  assign lslb_c = cnt_nz && (n <= 4'h8) && a8[3'(4'h8 - n)];
  assign asr_b = 8'($signed(a8) >>> n);
  assign asr_c = cnt_nz && a8[(n > 4'h8) ? 3'h7 : 3'(n - 4'h1)];
  assign lsr_w = req_i.dst >> n;
  assign wlsr_c = cnt_nz && req_i.dst[n - 4'h1];
  assign asr_w = 16'($signed(req_i.dst) >>> n);
  assign wasr_c = cnt_nz && req_i.dst[n - 4'h1];
  // Operation select; the whole result is written by this one process
  always_comb begin
    res_o.ext_addr = req_i.seg ? {req_i.bank, req_i.addr} : {4'h0, req_i.addr};
    res_o.value = req_i.dst;
    res_o.write_back = 1'b1;
    res_o.flags = flags_i;
    unique case (req_i.op)
      clsa_pkg::CLSA_OR: begin
        res_o.value = {8'h00, a8 | b8};
        res_o.flags.zero = ((a8 | b8) == 8'h00);
      end
      clsa_pkg::CLSA_XOR: begin
        res_o.value = {8'h00, a8 ^ b8};
        res_o.flags.zero = ((a8 ^ b8) == 8'h00);
      end
      clsa_pkg::CLSA_COMPARE, clsa_pkg::CLSA_COMPARE_IDX: begin
        res_o.write_back = 1'b0;
        res_o.flags = '{zero: s8[7:0] == 8'h00, half_carry_flag: s8[8], carry_bit: s8[9]};
      end
      clsa_pkg::CLSA_COMPARE_ZERO: begin
        res_o.write_back = 1'b0;
        res_o.flags = '{zero: a8 == `CLSA_ZERO_BYTE, half_carry_flag: 1'b0, carry_bit: 1'b0};
      end
      clsa_pkg::CLSA_WADD, clsa_pkg::CLSA_WSUB, clsa_pkg::CLSA_WCMP: begin
        res_o.value = w16[15:0];
        res_o.write_back = (req_i.op != clsa_pkg::CLSA_WCMP);
        res_o.flags = '{zero: w16[15:0] == 16'h0000, half_carry_flag: w16[16],
                        carry_bit: w16[17]};
      end
      clsa_pkg::CLSA_UMUL: res_o.value = {8'h00, a8} * {8'h00, b8};
      clsa_pkg::CLSA_INC, clsa_pkg::CLSA_BDEC: begin
        res_o.value = {8'h00, (req_i.op == clsa_pkg::CLSA_INC) ? a8 + 8'h01 : a8 - 8'h01};
        res_o.flags.zero = (res_o.value[7:0] == 8'h00);
        res_o.flags.half_carry_flag = (req_i.op == clsa_pkg::CLSA_INC) ?
                                      (a8[3:0] == 4'hf) : (a8[3:0] == 4'h0);
      end
      clsa_pkg::CLSA_WINC: res_o.value = req_i.dst + 16'h0001;
      clsa_pkg::CLSA_WDEC: res_o.value = req_i.dst - 16'h0001;
      clsa_pkg::CLSA_BLSR: begin
        res_o.value = {8'h00, sh_b};
        if (cnt_nz) res_o.flags.carry_bit = lsr_c;
      end
      clsa_pkg::CLSA_WLSR: begin
        res_o.value = lsr_w;
        if (cnt_nz) res_o.flags.carry_bit = wlsr_c;
      end
      clsa_pkg::CLSA_BLSL: begin
        res_o.value = {8'h00, lsl_w[7:0]};
        if (cnt_nz) res_o.flags.carry_bit = lslb_c;
      end
      clsa_pkg::CLSA_WLSL: begin
        res_o.value = lsl_w;
        if (cnt_nz) res_o.flags.carry_bit = lsl_c;
      end
      clsa_pkg::CLSA_BASR: begin
        res_o.value = {8'h00, asr_b};
        if (cnt_nz) res_o.flags.carry_bit = asr_c;
      end
      clsa_pkg::CLSA_WASR: begin
        res_o.value = asr_w;
        if (cnt_nz) res_o.flags.carry_bit = wasr_c;
      end
      default: res_o.write_back = 1'b0;
    endcase
  end
endmodule

// *** clsa_defs.svh ***
// Constants of the compare, logic and shift datapath
`ifndef CLSA_DEFS_SVH
`define CLSA_DEFS_SVH
`define CLSA_CLK_SHORT 3'h1
`define CLSA_CLK_RMW 3'h2
`define CLSA_CLK_EXT_RMW 3'h3
`define CLSA_CLK_PROG 3'h4
`define CLSA_CLK_PROG_EXT 3'h5
`define CLSA_ZERO_BYTE 8'h00
`define CLSA_RESET_ACC 16'h0000
`endif

// *** clsa_pkg.sv ***
// Types of the compare, logic and shift datapath
package clsa_pkg;
  typedef enum logic [4:0] {
    CLSA_OR = 5'h00,
    CLSA_XOR = 5'h01,
    CLSA_COMPARE = 5'h02,
    CLSA_COMPARE_ZERO = 5'h03,
    CLSA_COMPARE_IDX = 5'h04,
    CLSA_WADD = 5'h05,
    CLSA_WSUB = 5'h06,
    CLSA_WCMP = 5'h07,
    CLSA_UMUL = 5'h08,
    CLSA_INC = 5'h09,
    CLSA_BDEC = 5'h0a,
    CLSA_WINC = 5'h0b,
    CLSA_WDEC = 5'h0c,
    CLSA_BLSR = 5'h0d,
    CLSA_WLSR = 5'h0e,
    CLSA_BLSL = 5'h0f,
    CLSA_WLSL = 5'h10,
    CLSA_BASR = 5'h11,
    CLSA_WASR = 5'h12
  } clsa_op_t;
  typedef enum logic [1:0] {
    CLSA_AREA_INT = 2'h0,
    CLSA_AREA_NONE = 2'h1,
    CLSA_AREA_PROG = 2'h2
  } clsa_area_t;
  // One operation request from the sequencer
  typedef struct packed {
    clsa_op_t op;
    logic [15:0] dst;
    logic [15:0] src;
    logic [3:0] cnt;
    clsa_area_t area;
    logic seg;
    logic mem;
    logic mem_imm;
    logic [3:0] bank;
    logic [15:0] addr;
  } clsa_req_t;
  // Flags of the program status word handled here
  typedef struct packed {
    logic zero;
    logic half_carry_flag;
    logic carry_bit;
  } clsa_flags_t;
  // Result handed back to the sequencer
  typedef struct packed {
    logic [15:0] value;
    logic write_back;
    clsa_flags_t flags;
    logic [19:0] ext_addr;
  } clsa_res_t;
endpackage

// *** tb.sv ***
// Self-checking bench for the sequenced datapath
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic start_i = 1'b0;
  logic [1:0] div = 2'h0;
  logic cpu_en;
  clsa_pkg::clsa_req_t req = '0;
  clsa_pkg::clsa_flags_t fl = '0;
  logic busy_o;
  logic done_o;
  clsa_pkg::clsa_res_t res_o;
  logic [19:0] got;
  logic [19:0] msk = 20'hfffff;
  int lat;
  int n_errors = 0;
  int samples_checked = 0;
  clsa_clk_sel_model u_sel (.clk_i(clk_i), .rst_i(rst_i), .div_i(div), .cpu_en_o(cpu_en));
  clsa_alu DUT (.clk_i(clk_i), .rst_i(rst_i), .cpu_en_i(cpu_en), .start_i(start_i),
    .req_i(req), .flags_i(fl), .busy_o(busy_o), .done_o(done_o), .res_o(res_o));
  // Clock at 50 MHz
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One request m={imm,mem,seg,area}; counts edges to the answer, n=0 skips timing
  task automatic ck(input logic [4:0] o, input logic [15:0] d, s, input logic [3:0] c,
      input logic [4:0] m, input logic [2:0] f, input logic [19:0] e, input int n);
    @(negedge clk_i);
    req = '{clsa_pkg::clsa_op_t'(o), d, s, c, clsa_pkg::clsa_area_t'(m[1:0]), m[2], m[3],
      m[4], 4'ha, 16'h1234};
    fl = f;
    start_i = 1'b1;
    @(negedge clk_i);
    start_i = 1'b0;
    chk(20'(busy_o), 20'h1);
    lat = 1;
    while (done_o !== 1'b1 && lat < 64) begin
      @(negedge clk_i);
      lat++;
    end
    got = {res_o.value, res_o.write_back, res_o.flags};
    chk(got & msk, e);
    chk(20'(busy_o), 20'h0);
    if (m[2]) chk(res_o.ext_addr, 20'ha1234);
    if (n != 0) chk(20'(lat), 20'(n));
  endtask
  task automatic t_logic();
    ck(5'h00, 16'h00f0, 16'h000f, 4'h0, 5'h00, 3'h3, {16'h00ff, 4'hb}, 2);
    ck(5'h01, 16'h00aa, 16'h00aa, 4'h0, 5'h00, 3'h3, {16'h0000, 4'hf}, 2);
    ck(5'h00, 16'h0081, 16'h0042, 4'h0, 5'h10, 3'h0, {16'h00c3, 4'h8}, 3);
    ck(5'h01, 16'h00ff, 16'h000f, 4'h0, 5'h10, 3'h1, {16'h00f0, 4'h9}, 3);
  endtask
  // Compares: only write-back and flags are defined
  task automatic t_cmp();
    msk = 20'h0000f;
    ck(5'h02, 16'h0010, 16'h0020, 4'h0, 5'h00, 3'h0, 20'h1, 2);
    ck(5'h02, 16'h0055, 16'h0055, 4'h0, 5'h02, 3'h0, 20'h4, 5);
    ck(5'h02, 16'h0020, 16'h0001, 4'h0, 5'h06, 3'h0, 20'h2, 6);
    ck(5'h02, 16'h0020, 16'h0001, 4'h0, 5'h04, 3'h0, 20'h2, 3);
    ck(5'h03, 16'h0000, 16'h0000, 4'h0, 5'h00, 3'h7, 20'h4, 2);
    ck(5'h04, 16'h0005, 16'h0006, 4'h0, 5'h04, 3'h0, 20'h3, 3);
    ck(5'h07, 16'h1234, 16'h2234, 4'h0, 5'h00, 3'h0, 20'h1, 2);
    msk = 20'hfffff;
  endtask
  task automatic t_word();
    ck(5'h05, 16'hffff, 16'h0001, 4'h0, 5'h00, 3'h0, {16'h0000, 4'hf}, 2);
    ck(5'h06, 16'h1000, 16'h0001, 4'h0, 5'h00, 3'h5, {16'h0fff, 4'ha}, 2);
    ck(5'h08, 16'h00ff, 16'h00ff, 4'h0, 5'h00, 3'h5, {16'hfe01, 4'hd}, 2);
  endtask
  task automatic t_step();
    ck(5'h09, 16'h000f, 16'h0000, 4'h0, 5'h00, 3'h1, {16'h0010, 4'hb}, 2);
    ck(5'h09, 16'h00ff, 16'h0000, 4'h0, 5'h08, 3'h1, {16'h0000, 4'hf}, 3);
    ck(5'h0a, 16'h0000, 16'h0000, 4'h0, 5'h00, 3'h0, {16'h00ff, 4'ha}, 2);
    ck(5'h0a, 16'h0001, 16'h0000, 4'h0, 5'h0c, 3'h0, {16'h0000, 4'hc}, 4);
    ck(5'h0b, 16'hffff, 16'h0000, 4'h0, 5'h00, 3'h5, {16'h0000, 4'hd}, 2);
    ck(5'h0c, 16'h0000, 16'h0000, 4'h0, 5'h08, 3'h2, {16'hffff, 4'ha}, 3);
  endtask
  task automatic t_shift();
    ck(5'h0d, 16'h008d, 16'h0000, 4'h3, 5'h00, 3'h6, {16'h0011, 4'hf}, 2);
    ck(5'h0e, 16'h8005, 16'h0000, 4'h3, 5'h00, 3'h6, {16'h1000, 4'hf}, 2);
    ck(5'h0f, 16'h00b1, 16'h0000, 4'h3, 5'h00, 3'h6, {16'h0088, 4'hf}, 2);
    ck(5'h10, 16'h3001, 16'h0000, 4'h3, 5'h00, 3'h6, {16'h8008, 4'hf}, 2);
    ck(5'h11, 16'h008d, 16'h0000, 4'h3, 5'h00, 3'h6, {16'h00f1, 4'hf}, 2);
    ck(5'h12, 16'h8005, 16'h0000, 4'h3, 5'h00, 3'h6, {16'hf000, 4'hf}, 2);
  endtask
  // Slow instruction clock stretches the answer
  task automatic t_slow();
    div = 2'h2;
    ck(5'h00, 16'h0001, 16'h0002, 4'h0, 5'h00, 3'h0, {16'h0003, 4'h8}, 0);
    chk(20'(lat), 20'h3);
    div = 2'h0;
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (12) @(negedge clk_i);
    rst_i = 1'b0;
    t_logic();
    t_cmp();
    t_word();
    t_step();
    t_shift();
    t_slow();
    end_of_test();
  end
  // Watchdog
  initial begin
    #50us;
    n_errors++;
    end_of_test();
  end
endmodule
